// file: verif/fsim_host.sv
`timescale 1ns/1ns
module fsim_host #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  // clock and data line
  input wire logic i_clk,
  input wire logic i_sda,
  // driven lines
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // phases of 5+ clocks leave room for the 3-clock sync lag
  task automatic put(input logic b, output logic r);
    o_sda_low = !b;
    hold(5);
    o_scl = 1'b1;
    hold(2);
    r = i_sda;
    hold(3);
    o_scl = 1'b0;
    hold(2);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack, output logic [7:0] rx);
    logic nk;
    for (int i = 7; i >= 0; i--) begin
      put(tx[i], rx[i]);
    end
    put(ack, nk);
  endtask
  task automatic start();
    o_sda_low = 1'b0;
    hold(3);
    o_scl = 1'b1;
    hold(5);
    o_sda_low = 1'b1;
    hold(5);
    o_scl = 1'b0;
    hold(2);
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    hold(3);
    o_scl = 1'b1;
    hold(5);
    o_sda_low = 1'b0;
    hold(5);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] x;
    start();
    xfer({ADDR, 1'b0}, 1'b1, x);
    xfer(ptr, 1'b1, x);
    xfer(d, 1'b1, x);
    stop();
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    logic [7:0] x;
    start();
    xfer({ADDR, 1'b0}, 1'b1, x);
    xfer(ptr, 1'b1, x);
    start();
    xfer({ADDR, 1'b1}, 1'b1, x);
    xfer(8'hff, 1'b1, d);
    stop();
  endtask
endmodule // fsim_host

// file: verif/fsim_props.sv
`timescale 1ns/1ns
module fsim_props (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // watched inputs
  input wire logic i_scl,
  input wire logic i_oc_neg,
  input wire logic i_pin_irq_mode,
  // watched outputs
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic o_irq_pin_o,
  input wire logic o_irq_pin_oe
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  AST_DRIVE_LOW: assert property (!o_irq_pin_o && !o_sda_o)
    else $error("pin value not low");
  AST_RST_QUIET: assert property ($rose(i_rstn) |-> !o_irq_pin_oe)
    else $error("irq after reset");
  AST_NO_MODE: assert property (!i_pin_irq_mode [*3] |-> !o_irq_pin_oe)
    else $error("irq outside irq mode");
  AST_ROSE_MODE: assert property ($rose(o_irq_pin_oe) |-> $past(i_pin_irq_mode) || $past(i_pin_irq_mode, 2))
    else $error("irq rose without mode");
  AST_MODE_DROP: assert property ($fell(i_pin_irq_mode) |-> ##[1:2] !o_irq_pin_oe)
    else $error("irq held after mode drop");
  AST_OC_NEG_IRQ: assert property ($rose(i_oc_neg) && i_pin_irq_mode |-> ##[2:6] o_irq_pin_oe)
    else $error("no irq after overcurrent");
  // bus traffic may clear flags, so only quiet stretches count
  AST_STICKY: assert property (i_scl [*6] ##0 (o_irq_pin_oe && i_pin_irq_mode) |=> o_irq_pin_oe || !i_pin_irq_mode)
    else $error("irq dropped without read");
  AST_SDA_LATE: assert property ($changed(o_sda_oe) |-> !$past(i_scl, 2))
    else $error("data line moved in clock high");
  C_IRQ: cover property ($rose(o_irq_pin_oe));
  C_RELEASE: cover property ($fell(o_irq_pin_oe) && i_pin_irq_mode);
  C_ACK: cover property ($rose(o_sda_oe));
endmodule // fsim_props
bind fsim_top fsim_props fsim_props_inst (.i_sys_clk, .i_rstn, .i_scl, .i_oc_neg, .i_pin_irq_mode, .o_sda_o,
  .o_sda_oe, .o_irq_pin_o, .o_irq_pin_oe);

// file: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic mode = 1'b0;
  logic [10:0] ev = '0;
  logic scl, host_low, sda_o, sda_oe, irq_o, irq_oe;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int mb [5] = '{0, 2, 3, 6, 8};
  logic [10:0] tbl [11] = '{11'h200, 11'h400, 11'h100, 11'h080, 11'h040, 11'h020, 11'h010, 11'h00c, 11'h003,
    11'h008, 11'h002};
  logic [7:0] st [11] = '{8'h01, 8'h01, 8'h02, 8'h04, 8'h08, 8'h08, 8'h08, 8'h80, 8'h80, 8'h00, 8'h00};
  // both lines pulled up; host or device may pull data low, only the device pulls irq low
  wire sda_line = !(host_low || (sda_oe && !sda_o));
  wire irq_line = !(irq_oe && !irq_o);
  always #5 clk = !clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      results();
    end
  end
  fsim_top fsim_top_inst (
    .i_sys_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_sda(sda_line), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_diag_active(ev[0]), .i_diag_fault(ev[1]), .i_cal_active(ev[2]), .i_cal_fail(ev[3]),
    .i_seq_done(ev[4]), .i_diag_done(ev[5]), .i_cal_done(ev[6]), .i_droop_cmp(ev[7]),
    .i_over_temp(ev[8]), .i_oc_pos(ev[9]), .i_oc_neg(ev[10]), .i_pin_irq_mode(mode),
    .o_irq_pin_o(irq_o), .o_irq_pin_oe(irq_oe)
  );
  fsim_host #(.ADDR(fsim_pkg::DEV_ADDR_DEFAULT)) fsim_host_inst (
    .i_clk(clk), .i_sda(sda_line), .o_scl(scl), .o_sda_low(host_low)
  );
  function automatic logic pin_exp(input logic [7:0] s, input logic [4:0] m, input logic md);
    return md && |({s[7], s[3:0]} & ~m);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic run(input int idx, input logic [4:0] m, input logic md);
    logic [7:0] d;
    mode = md;
    fsim_host_inst.wr(8'h02, {3'h0, m});
    fsim_host_inst.rd(8'h02, d);
    chk(d, {3'h0, m});
    ev = tbl[idx];
    repeat (3) @(negedge clk);
    ev = '0;
    repeat (30) @(negedge clk);
    chk({7'h0, irq_line}, {7'h0, !pin_exp(st[idx], m, md)});
    fsim_host_inst.rd(8'h01, d);
    chk(d, st[idx]);
    fsim_host_inst.rd(8'h01, d);
    chk(d, 8'h00);
    chk({7'h0, irq_line}, 8'h01);
  endtask
  initial begin
    logic [7:0] d;
    int k;
    void'($urandom(32'hf7bc));
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (5) @(negedge clk);
    fsim_host_inst.rd(8'h01, d);
    chk(d, 8'h00);
    fsim_host_inst.rd(8'h02, d);
    chk(d, 8'h18);
    fsim_host_inst.rd(8'h05, d);
    chk(d, 8'h00);
    for (int i = 0; i < 11; i++) begin
      run(i, 5'h00, 1'b1);
    end
    // flag bits of the status byte must not take host writes
    fsim_host_inst.wr(8'h01, 8'hff);
    fsim_host_inst.rd(8'h01, d);
    chk(d, 8'h70);
    chk({7'h0, irq_line}, 8'h01);
    fsim_host_inst.wr(8'h01, 8'h00);
    for (int b = 0; b < 5; b++) begin
      run(mb[b], 5'(1 << b), 1'b1);
    end
    for (int i = 0; i < 10; i++) begin
      k = $urandom % 11;
      run(k == 1 ? 0 : k, 5'($urandom), 1'($urandom));
    end
    results();
  end
endmodule // tb_top

// file: verilog/fsim_flag_bank.sv
`timescale 1ns/1ns
module fsim_flag_bank (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // flags
  fsim_link_if.bank lnk
);
  typedef struct packed {
    logic [fsim_pkg::FLAG_W-1:0] flags;
  } fsim_bank_state_t;

  fsim_bank_state_t r;
  fsim_bank_state_t n;

  // set beats clear so an event during the read is kept
  always_comb begin
    n = r;
    n.flags = lnk.set | (r.flags & ~({fsim_pkg::FLAG_W{lnk.clr}}));
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign lnk.flags = r.flags;
endmodule // fsim_flag_bank

// file: verilog/fsim_irq_gate.sv
`timescale 1ns/1ns
module fsim_irq_gate (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // flags in, pin enable out
  fsim_link_if.gate lnk
);
  typedef struct packed {
    logic pin_oe;
  } fsim_gate_state_t;

  fsim_gate_state_t r;
  fsim_gate_state_t n;

  always_comb begin
    n = r;
    // outside interrupt mode the pin is a trigger input, never driven
    n.pin_oe = lnk.irq_mode & (|(lnk.flags & ~lnk.mask));
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign lnk.pin_oe = r.pin_oe;
endmodule // fsim_irq_gate

// file: verilog/fsim_link_if.sv
`timescale 1ns/1ns
interface fsim_link_if;
  logic [fsim_pkg::FLAG_W-1:0] set;
  logic clr;
  logic [fsim_pkg::FLAG_W-1:0] flags;
  logic [fsim_pkg::FLAG_W-1:0] mask;
  logic irq_mode;
  logic pin_oe;

  modport ctl (output set, output clr, output mask, output irq_mode, input flags, input pin_oe);
  modport bank (input set, input clr, output flags);
  modport gate (input flags, input mask, input irq_mode, output pin_oe);
endinterface

// file: verilog/fsim_pkg.sv
package fsim_pkg;

  // flag vector layout, shared by bank, gate and register file
  localparam int unsigned FLAG_W = 5;
  localparam int unsigned FLAG_OC = 0;
  localparam int unsigned FLAG_OT = 1;
  localparam int unsigned FLAG_DROOP = 2;
  localparam int unsigned FLAG_DONE = 3;
  localparam int unsigned FLAG_FAULT = 4;

  // register offsets and reset values
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_MASK = 8'h02;
  localparam logic [4:0] MASK_RESET = 5'h18;
  localparam logic [2:0] RESV_RESET = 3'h0;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // field positions inside the bytes
  localparam int unsigned STAT_FAULT_POS = 7;
  localparam int unsigned STAT_RESV_LSB = 4;
  localparam int unsigned MASK_RESV_LSB = 5;

  // serial bus
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // synchroniser lanes
  localparam int unsigned SYNC_W = 6;
  localparam int unsigned SYNC_SCL = 0;
  localparam int unsigned SYNC_SDA = 1;
  localparam int unsigned SYNC_DROOP = 2;
  localparam int unsigned SYNC_OT = 3;
  localparam int unsigned SYNC_OCP = 4;
  localparam int unsigned SYNC_OCN = 5;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_ACK_A = 9'h004,
    ST_REG   = 9'h008,
    ST_ACK_R = 9'h010,
    ST_WR    = 9'h020,
    ST_ACK_W = 9'h040,
    ST_RD    = 9'h080,
    ST_MACK  = 9'h100
  } fsim_bus_st_t;

endpackage

// file: verilog/fsim_top.sv
// Contract
// - diagnostics fault sets fault result flag
// - calibration failure sets same fault flag
// - flags sticky, cleared only by status read
// - sequence, diagnostics or calibration end sets done
// - supply below droop threshold sets droop flag
// - die over temperature sets thermal flag
// - overcurrent on either output sets flag
// - mask bit one blocks its flag's interrupt
// - mask matters only in interrupt pin mode
// - mask resets to 24, upper bits zero
`timescale 1ns/1ns
module fsim_top #(
  parameter logic [6:0] DEV_ADDR = fsim_pkg::DEV_ADDR_DEFAULT
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // serial control bus, open drain data
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // engine events, same clock
  input wire logic i_diag_active,
  input wire logic i_diag_fault,
  input wire logic i_cal_active,
  input wire logic i_cal_fail,
  input wire logic i_seq_done,
  input wire logic i_diag_done,
  input wire logic i_cal_done,
  // analog protection comparators, asynchronous
  input wire logic i_droop_cmp,
  input wire logic i_over_temp,
  input wire logic i_oc_pos,
  input wire logic i_oc_neg,
  // trigger_irq_pin function, same clock
  input wire logic i_pin_irq_mode,
  // trigger_irq_pin, open drain active low
  output logic o_irq_pin_o,
  output logic o_irq_pin_oe
);

  typedef struct packed {
    logic [fsim_pkg::SYNC_W-1:0] sync1;
    logic [fsim_pkg::SYNC_W-1:0] sync2;
    logic scl_d;
    logic sda_d;
    fsim_pkg::fsim_bus_st_t st;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic rw;
    logic nack;
    logic [7:0] ptr;
    logic sda_o;
    logic sda_oe;
    logic [2:0] stat_resv;
    logic [2:0] mask_resv;
    logic [fsim_pkg::FLAG_W-1:0] mask;
    logic clr;
    logic irq_o;
  } fsim_top_state_t;

  fsim_top_state_t r;
  fsim_top_state_t n;

  fsim_link_if lnk ();

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] rdata;

  // the second stage alone feeds logic; the first is read only by it
  assign scl_s = r.sync2[fsim_pkg::SYNC_SCL];
  assign sda_s = r.sync2[fsim_pkg::SYNC_SDA];
  assign scl_rise = scl_s & ~r.scl_d;
  assign scl_fall = ~scl_s & r.scl_d;
  assign bus_start = scl_s & r.scl_d & r.sda_d & ~sda_s;
  assign bus_stop = scl_s & r.scl_d & ~r.sda_d & sda_s;

  // flag sources
  assign lnk.set[fsim_pkg::FLAG_OC] = r.sync2[fsim_pkg::SYNC_OCP] | r.sync2[fsim_pkg::SYNC_OCN];
  assign lnk.set[fsim_pkg::FLAG_OT] = r.sync2[fsim_pkg::SYNC_OT];
  // comparator trips at the droop_threshold level set elsewhere
  assign lnk.set[fsim_pkg::FLAG_DROOP] = r.sync2[fsim_pkg::SYNC_DROOP];
  assign lnk.set[fsim_pkg::FLAG_DONE] = i_seq_done | i_diag_done | i_cal_done;
  assign lnk.set[fsim_pkg::FLAG_FAULT] = (i_diag_active & i_diag_fault)
                                       | (i_cal_active & i_cal_fail);
  assign lnk.clr = r.clr;
  assign lnk.mask = r.mask;
  assign lnk.irq_mode = i_pin_irq_mode;

  fsim_flag_bank u_bank (
    .i_sys_clk (i_sys_clk),
    .i_rstn (i_rstn),
    .lnk (lnk.bank)
  );

  fsim_irq_gate u_gate (
    .i_sys_clk (i_sys_clk),
    .i_rstn (i_rstn),
    .lnk (lnk.gate)
  );

  // read mux; offsets outside this block read as zero
  always_comb begin
    rdata = fsim_pkg::RDATA_UNMAPPED;
    if (r.ptr == fsim_pkg::REG_STATUS) begin
      rdata[fsim_pkg::STAT_FAULT_POS] = lnk.flags[fsim_pkg::FLAG_FAULT];
      rdata[fsim_pkg::STAT_RESV_LSB +: 3] = r.stat_resv;
      rdata[fsim_pkg::FLAG_DONE:0] = lnk.flags[fsim_pkg::FLAG_DONE:0];
    end else if (r.ptr == fsim_pkg::REG_MASK) begin
      rdata[fsim_pkg::MASK_RESV_LSB +: 3] = r.mask_resv;
      rdata[fsim_pkg::FLAG_W-1:0] = r.mask;
    end
  end

  always_comb begin
    n = r;
    n.sync1 = {i_oc_neg, i_oc_pos, i_over_temp, i_droop_cmp, i_sda, i_scl};
    n.sync2 = r.sync1;
    n.scl_d = scl_s;
    n.sda_d = sda_s;
    n.clr = 1'b0;
    n.sda_o = 1'b0;
    n.irq_o = 1'b0;
    if (bus_start) begin
      // repeated start is accepted from any state
      n.st = fsim_pkg::ST_ADDR;
      n.cnt = 4'h0;
      n.sda_oe = 1'b0;
    end else if (bus_stop) begin
      n.st = fsim_pkg::ST_IDLE;
      n.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (r.st)
        fsim_pkg::ST_ADDR, fsim_pkg::ST_REG, fsim_pkg::ST_WR: begin
          n.shreg = {r.shreg[6:0], sda_s};
          n.cnt = r.cnt + 4'h1;
        end
        fsim_pkg::ST_RD: begin
          n.cnt = r.cnt + 4'h1;
        end
        fsim_pkg::ST_MACK: begin
          n.nack = sda_s;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (r.st)
        fsim_pkg::ST_ADDR: begin
          if (r.cnt == fsim_pkg::BYTE_BITS) begin
            if (r.shreg[7:1] == DEV_ADDR) begin
              n.rw = r.shreg[0];
              n.sda_oe = 1'b1;
              n.st = fsim_pkg::ST_ACK_A;
            end else begin
              n.st = fsim_pkg::ST_IDLE;
            end
          end
        end
        fsim_pkg::ST_ACK_A: begin
          if (r.rw) begin
            n.sda_oe = ~rdata[7];
            n.shreg = {rdata[6:0], 1'b0};
            n.cnt = 4'h0;
            n.ptr = r.ptr + 8'h01;
            // clearing at load time: the byte already holds the flags
            n.clr = (r.ptr == fsim_pkg::REG_STATUS);
            n.st = fsim_pkg::ST_RD;
          end else begin
            n.sda_oe = 1'b0;
            n.cnt = 4'h0;
            n.st = fsim_pkg::ST_REG;
          end
        end
        fsim_pkg::ST_REG: begin
          if (r.cnt == fsim_pkg::BYTE_BITS) begin
            n.ptr = r.shreg;
            n.sda_oe = 1'b1;
            n.st = fsim_pkg::ST_ACK_R;
          end
        end
        fsim_pkg::ST_ACK_R, fsim_pkg::ST_ACK_W: begin
          n.sda_oe = 1'b0;
          n.cnt = 4'h0;
          n.st = fsim_pkg::ST_WR;
        end
        fsim_pkg::ST_WR: begin
          if (r.cnt == fsim_pkg::BYTE_BITS) begin
            // status flags are read only; only its spare bits store
            if (r.ptr == fsim_pkg::REG_STATUS) begin
              n.stat_resv = r.shreg[fsim_pkg::STAT_RESV_LSB +: 3];
            end else if (r.ptr == fsim_pkg::REG_MASK) begin
              n.mask_resv = r.shreg[fsim_pkg::MASK_RESV_LSB +: 3];
              n.mask = r.shreg[fsim_pkg::FLAG_W-1:0];
            end
            n.ptr = r.ptr + 8'h01;
            n.sda_oe = 1'b1;
            n.st = fsim_pkg::ST_ACK_W;
          end
        end
        fsim_pkg::ST_RD: begin
          if (r.cnt == fsim_pkg::BYTE_BITS) begin
            n.sda_oe = 1'b0;
            n.st = fsim_pkg::ST_MACK;
          end else begin
            n.sda_oe = ~r.shreg[7];
            n.shreg = {r.shreg[6:0], 1'b0};
          end
        end
        fsim_pkg::ST_MACK: begin
          if (r.nack) begin
            n.st = fsim_pkg::ST_IDLE;
          end else begin
            n.sda_oe = ~rdata[7];
            n.shreg = {rdata[6:0], 1'b0};
            n.cnt = 4'h0;
            n.ptr = r.ptr + 8'h01;
            n.clr = (r.ptr == fsim_pkg::REG_STATUS);
            n.st = fsim_pkg::ST_RD;
          end
        end
        default: begin
          n.st = fsim_pkg::ST_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r.sync1 <= '0;
      r.sync2 <= '0;
      r.scl_d <= 1'b0;
      r.sda_d <= 1'b0;
      r.st <= fsim_pkg::ST_IDLE;
      r.cnt <= 4'h0;
      r.shreg <= 8'h00;
      r.rw <= 1'b0;
      r.nack <= 1'b0;
      r.ptr <= 8'h00;
      r.sda_o <= 1'b0;
      r.sda_oe <= 1'b0;
      r.stat_resv <= fsim_pkg::RESV_RESET;
      r.mask_resv <= fsim_pkg::RESV_RESET;
      r.mask <= fsim_pkg::MASK_RESET;
      r.clr <= 1'b0;
      r.irq_o <= 1'b0;
    end else begin
      r <= n;
    end
  end

  assign o_sda_o = r.sda_o;
  assign o_sda_oe = r.sda_oe;
  assign o_irq_pin_o = r.irq_o;
  assign o_irq_pin_oe = lnk.pin_oe;

endmodule // fsim_top
